// File: iemb_pkg.sv
/*
 * Shared constants for the interrupt enable mask bank: register map,
 * implemented-bit masks, reset values, priority field layout and the
 * bit position of each named source's enable bit (not every implemented bit of registers b and c).
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package iemb_pkg;

    // Bank geometry
    localparam int          NUM_REGS        = 4;
    localparam int          REG_W           = 16;
    localparam int          NUM_SRC         = NUM_REGS * REG_W;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;

    // Register map, byte addresses
    localparam logic [11:0] OFF_ENABLE_BASE = 12'h000;
    localparam logic [11:0] OFF_FLAG_BASE   = 12'h010;
    localparam logic [11:0] OFF_PEND_BASE   = 12'h020;
    localparam logic [11:0] OFF_BEST        = 12'h030;
    localparam logic [11:0] OFF_PRIO_BASE   = 12'h040;
    localparam int          PRIO_WORDS      = 16;

    // Implemented bits of registers b, c, d, e
    localparam logic [15:0] IMPL_B          = 16'hFFFB;
    localparam logic [15:0] IMPL_C          = 16'hDFFF;
    localparam logic [15:0] IMPL_D          = 16'h21FF;
    localparam logic [15:0] IMPL_E          = 16'h00F6;

    // Reset values
    localparam logic [15:0] ENABLE_RESET    = 16'h0000;
    localparam logic [15:0] FLAG_RESET      = 16'h0000;
    localparam logic [2:0]  PRIO_RESET      = 3'h4;
    localparam logic [2:0]  PRIO_OFF        = 3'h0;

    // Priority field layout: four 3-bit fields per word, 4 bits apart
    localparam int          PRIO_FIELD_W    = 3;
    localparam int          PRIO_STRIDE     = 4;
    localparam int          PRIO_PER_WORD   = 4;

    // Best-pending readout layout
    localparam int          BEST_SRC_LSB    = 0;
    localparam int          BEST_PRIO_LSB   = 8;

    // Register b positions
    localparam int POS_PIN_CHANGE_IRQ_EN             = 3;
    localparam int POS_TWOWIRE_A_MASTER_IRQ_EN       = 1;
    localparam int POS_TWOWIRE_A_SLAVE_IRQ_EN        = 0;
    // Register c positions
    localparam int POS_TIMER_SIX_IRQ_EN              = 15;
    localparam int POS_XFER_CH4_DONE_IRQ_EN          = 14;
    localparam int POS_OUT_CMP_CH8_IRQ_EN            = 12;
    localparam int POS_OUT_CMP_CH5_IRQ_EN            = 9;
    localparam int POS_IN_CAPT_CH6_IRQ_EN            = 8;
    localparam int POS_IN_CAPT_CH3_IRQ_EN            = 5;
    localparam int POS_XFER_CH3_DONE_IRQ_EN          = 4;
    localparam int POS_CAN_A_EVENT_IRQ_EN            = 3;
    localparam int POS_CAN_A_RX_IRQ_EN               = 2;
    localparam int POS_SERIAL_PERIPH_B_EVENT_IRQ_EN  = 1;
    localparam int POS_SERIAL_PERIPH_B_ERROR_IRQ_EN  = 0;
    // Register d positions
    localparam int POS_XFER_CH5_DONE_IRQ_EN          = 13;
    localparam int POS_CAN_B_EVENT_IRQ_EN            = 8;
    localparam int POS_CAN_B_RX_IRQ_EN               = 7;
    localparam int POS_EXT_PIN_IRQ4_EN               = 6;
    localparam int POS_EXT_PIN_IRQ3_EN               = 5;
    localparam int POS_TIMER_NINE_IRQ_EN             = 4;
    localparam int POS_TIMER_EIGHT_IRQ_EN            = 3;
    localparam int POS_TWOWIRE_B_MASTER_IRQ_EN       = 2;
    localparam int POS_TWOWIRE_B_SLAVE_IRQ_EN        = 1;
    localparam int POS_TIMER_SEVEN_IRQ_EN            = 0;
    // Register e positions
    localparam int POS_CAN_B_TX_REQ_IRQ_EN           = 7;
    localparam int POS_CAN_A_TX_REQ_IRQ_EN           = 6;
    localparam int POS_XFER_CH7_DONE_IRQ_EN          = 5;
    localparam int POS_XFER_CH6_DONE_IRQ_EN          = 4;
    localparam int POS_ASYNC_SERIAL_B_ERROR_IRQ_EN   = 2;
    localparam int POS_ASYNC_SERIAL_A_ERROR_IRQ_EN   = 1;

    // Implemented-bit mask of bank register idx
    function automatic logic [15:0] impl_mask(input int idx);
        logic [15:0] m;
        m = 16'h0000;
        if (idx == 0) begin
            m = IMPL_B;
        end else if (idx == 1) begin
            m = IMPL_C;
        end else if (idx == 2) begin
            m = IMPL_D;
        end else if (idx == 3) begin
            m = IMPL_E;
        end
        return m;
    endfunction

endpackage

// File: iemb_bank.sv
/*
 * Interrupt enable mask bank: four 16-bit enable registers, their flag
 * registers, a 3-bit priority per source, and the gating that passes
 * flagged, enabled, non-zero-priority requests to the arbitration logic.
 * Assumes an APB master on pclk, source requests synchronous to pclk,
 * and an arbiter downstream that consumes req_to_arb and best_*.
 */
// Register access over APB and the register offsets were left to the implementer.
// Notes on behaviour
// - An enable bit at 1 passes its flagged request; at 0 blocks it.
// - Unimplemented enable bit positions read 0 and ignore writes.
// - Register b: bit 3 pin change, bit 1 twowire A master, bit 0 slave.
// - Register c high byte: timer 6, channel 4, compare 8..5, capture 6; bit 13 absent.
// - Register c low byte: capture 5..3, channel 3, CAN A event/rx, SPI B event/error.
// - Register d high byte: only bit 13 channel 5 and bit 8 CAN B event.
// - Register d low byte: CAN B rx, ext 4/3, timers 9/8, twowire B, timer 7.
// - Register e: bits 15-8 absent; CAN B/A transmit, channels 7 and 6.
// - Register e: bit 2 UART B error, bit 1 UART A error; bits 3, 0 absent.
// - A flag reads 1 once its request occurred, else 0; enables act on flags.
// - Priority 000 disables a source whatever its enable; 7 is highest.
`timescale 1ns/1ps

module iemb_bank
    import iemb_pkg::*;
#(
    parameter int SRC_COUNT = NUM_SRC
) (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [DATA_W-1:0]    pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [DATA_W-1:0]    prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic [SRC_COUNT-1:0] src_req,
    output logic      [SRC_COUNT-1:0] req_to_arb,
    output logic      [2:0]           best_prio,
    output logic      [5:0]           best_src,
    output logic                      irq
);

    // Address regions
    typedef enum logic [5:0] {
        IEMB_RGN_NONE   = 6'b000001,
        IEMB_RGN_ENABLE = 6'b000010,
        IEMB_RGN_FLAG   = 6'b000100,
        IEMB_RGN_PEND   = 6'b001000,
        IEMB_RGN_BEST   = 6'b010000,
        IEMB_RGN_PRIO   = 6'b100000
    } iemb_rgn_t;

    logic [REG_W-1:0]        enable_reg [NUM_REGS];
    logic [REG_W-1:0]        flag_reg   [NUM_REGS];
    logic [PRIO_FIELD_W-1:0] prio_reg   [NUM_SRC];
    logic [REG_W-1:0]        flag_clr;
    logic [NUM_SRC-1:0]      pass_vec;
    logic [2:0]              next_best_prio;
    logic [5:0]              next_best_src;
    logic [DATA_W-1:0]       next_prdata;
    iemb_rgn_t               rgn;
    logic                    wr_access;
    logic [1:0]              reg_idx;
    logic [3:0]              prio_word;

    // Region decode from byte address; misaligned addresses are unmapped
    function automatic iemb_rgn_t decode(input logic [ADDR_W-1:0] a);
        iemb_rgn_t r;
        r = IEMB_RGN_NONE;
        if (a[1:0] != 2'h0) begin
            r = IEMB_RGN_NONE;
        end else if (a[11:4] == OFF_ENABLE_BASE[11:4]) begin
            r = IEMB_RGN_ENABLE;
        end else if (a[11:4] == OFF_FLAG_BASE[11:4]) begin
            r = IEMB_RGN_FLAG;
        end else if (a[11:4] == OFF_PEND_BASE[11:4]) begin
            r = IEMB_RGN_PEND;
        end else if (a == OFF_BEST) begin
            r = IEMB_RGN_BEST;
        end else if (a[11:6] == OFF_PRIO_BASE[11:6]) begin
            r = IEMB_RGN_PRIO;
        end
        return r;
    endfunction

    // Merge a byte-strobed write into a 16-bit register, honouring the
    // implemented-bit mask so absent positions never change
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] wr_v,
                                            input logic [1:0]  strb,
                                            input logic [15:0] impl);
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & impl;
        return (old_v & ~lane) | (wr_v & lane);
    endfunction

    assign rgn       = decode(paddr);
    assign reg_idx   = paddr[3:2];
    assign prio_word = paddr[5:2];
    // Writes land only on the completing access edge
    assign wr_access = psel & penable & pwrite & pready;
    // Write-one-to-clear lanes aimed at the flag region; kept outside the
    // clocked process so no temporary is assigned there
    assign flag_clr  = (wr_access && rgn == IEMB_RGN_FLAG) ? (pwdata[15:0] & {{8{pstrb[1]}}, {8{pstrb[0]}}})
                                                           : 16'h0000;

    // Zero wait states: read data is captured in the setup cycle
    assign pready = 1'b1;

    // Enable registers, software read/write, absent bits forced low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                enable_reg[r] <= ENABLE_RESET;
            end
        end else if (wr_access && rgn == IEMB_RGN_ENABLE) begin
            enable_reg[reg_idx] <= merge16(enable_reg[reg_idx], pwdata[15:0], pstrb[1:0],
                                           impl_mask(int'(reg_idx)));
        end
    end

    // Flags: set by the source whatever the enable, cleared by writing 1.
    // A request in the clearing cycle wins so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                flag_reg[r] <= FLAG_RESET;
            end
        end else begin
            for (int r = 0; r < NUM_REGS; r++) begin
                flag_reg[r] <= ((flag_reg[r] & ~((reg_idx == r[1:0]) ? flag_clr : 16'h0000))
                                | src_req[r*REG_W +: REG_W]) & impl_mask(r);
            end
        end
    end

    // Priority fields, four per word; reset to a mid-level priority
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < NUM_SRC; s++) begin
                prio_reg[s] <= PRIO_RESET;
            end
        end else if (wr_access && rgn == IEMB_RGN_PRIO) begin
            for (int j = 0; j < PRIO_PER_WORD; j++) begin
                if (pstrb[j / 2]) begin
                    prio_reg[int'(prio_word) * PRIO_PER_WORD + j] <= pwdata[j*PRIO_STRIDE +: PRIO_FIELD_W];
                end
            end
        end
    end

    // Gate each flagged request by its enable and a non-zero priority
    always_comb begin
        for (int s = 0; s < NUM_SRC; s++) begin
            pass_vec[s] = flag_reg[s / REG_W][s % REG_W]
                          & enable_reg[s / REG_W][s % REG_W]
                          & (prio_reg[s] != PRIO_OFF);
        end
    end

    // Highest passing priority; ties go to the lowest source number,
    // which keeps the search a plain priority chain rather than a tree
    always_comb begin
        next_best_prio = PRIO_OFF;
        next_best_src  = 6'h00;
        for (int s = 0; s < NUM_SRC; s++) begin
            if (pass_vec[s] && prio_reg[s] > next_best_prio) begin
                next_best_prio = prio_reg[s];
                next_best_src  = 6'(s);
            end
        end
    end

    // Registered outputs toward the arbiter: one cycle behind the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_to_arb <= '0;
            best_prio  <= PRIO_OFF;
            best_src   <= 6'h00;
            irq        <= 1'b0;
        end else begin
            req_to_arb <= pass_vec[SRC_COUNT-1:0];
            best_prio  <= next_best_prio;
            best_src   <= next_best_src;
            irq        <= |pass_vec;
        end
    end

    // Read mux; absent enable and flag bits come back as zero
    always_comb begin
        next_prdata = '0;
        if (rgn == IEMB_RGN_ENABLE) begin
            next_prdata[15:0] = enable_reg[reg_idx] & impl_mask(int'(reg_idx));
        end else if (rgn == IEMB_RGN_FLAG) begin
            next_prdata[15:0] = flag_reg[reg_idx];
        end else if (rgn == IEMB_RGN_PEND) begin
            next_prdata[15:0] = pass_vec[int'(reg_idx) * REG_W +: REG_W];
        end else if (rgn == IEMB_RGN_BEST) begin
            next_prdata[BEST_SRC_LSB +: 6]  = best_src;
            next_prdata[BEST_PRIO_LSB +: 3] = best_prio;
        end else if (rgn == IEMB_RGN_PRIO) begin
            for (int j = 0; j < PRIO_PER_WORD; j++) begin
                next_prdata[j*PRIO_STRIDE +: PRIO_FIELD_W] = prio_reg[int'(prio_word) * PRIO_PER_WORD + j];
            end
        end
    end

    // Capture read data and the error answer in the setup cycle so both
    // come from flops; the value is the one seen at the setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= pwrite ? '0 : next_prdata;
            pslverr <= (rgn == IEMB_RGN_NONE);
        end else if (!psel) begin
            prdata  <= '0;
            pslverr <= 1'b0;
        end
    end

endmodule // iemb_bank

// File: iemb_bank_properties.sv
/* Port checker for the enable mask bank.
   Assumes it is bound to every iemb_bank instance. */
`timescale 1ns/1ps
module iemb_bank_chk
    import iemb_pkg::*;
#(
    parameter int SRC_COUNT = NUM_SRC
) (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic [DATA_W-1:0]    pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [DATA_W-1:0]    prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [SRC_COUNT-1:0] src_req,
    input wire logic [SRC_COUNT-1:0] req_to_arb,
    input wire logic [2:0]           best_prio,
    input wire logic [5:0]           best_src,
    input wire logic                 irq
);
    // All checks live in the single pclk domain
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic rd_acc = psel && penable && !pwrite;

    property p_irq; irq == (req_to_arb != '0); endproperty
    a_irq: assert property (p_irq) else $error("irq disagrees with passing requests");
    property p_best; (req_to_arb != '0) |-> req_to_arb[best_src] && best_prio != 3'h0; endproperty
    a_best: assert property (p_best) else $error("best source is not a passing one");
    property p_idle; (req_to_arb == '0) |-> best_prio == 3'h0; endproperty
    a_idle: assert property (p_idle) else $error("priority shown with nothing passing");
    // Requests need two edges to reach the outputs, so both edges after release are quiet
    property p_rst; $rose(presetn) |-> req_to_arb == '0 ##1 req_to_arb == '0; endproperty
    a_rst: assert property (p_rst) else $error("request passed right after reset");
    property p_err; psel && penable && paddr[1:0] != 2'b00 |-> pslverr && prdata == '0; endproperty
    a_err: assert property (p_err) else $error("misaligned access not refused");
    property p_rdb; rd_acc && paddr == 12'h000 |-> (prdata & 32'hFFFF_0004) == '0; endproperty
    a_rdb: assert property (p_rdb) else $error("absent bit set in register b");
    property p_rdc; rd_acc && paddr == 12'h004 |-> (prdata & 32'hFFFF_2000) == '0; endproperty
    a_rdc: assert property (p_rdc) else $error("absent bit set in register c");
    property p_rdd; rd_acc && paddr == 12'h008 |-> (prdata & 32'hFFFF_DE00) == '0; endproperty
    a_rdd: assert property (p_rdd) else $error("absent bit set in register d");
    property p_rde; rd_acc && paddr == 12'h00C |-> (prdata & 32'hFFFF_FF09) == '0; endproperty
    a_rde: assert property (p_rde) else $error("absent bit set in register e");
endmodule // iemb_bank_chk

bind iemb_bank iemb_bank_chk #(.SRC_COUNT(SRC_COUNT)) u_iemb_bank_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req), .req_to_arb(req_to_arb),
    .best_prio(best_prio), .best_src(best_src), .irq(irq));

// File: iemb_bank_tb.sv
/* Self-checking testbench for the enable mask bank.
   Assumes the checker file is compiled alongside and the package first. */
`timescale 1ns/1ps
module iemb_bank_tb
    import iemb_pkg::*;
;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [ADDR_W-1:0] paddr, ea, fa, pa;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0]        pstrb;
    logic [NUM_SRC-1:0] src_req, req_to_arb;
    logic [2:0]        best_prio;
    logic [5:0]        best_src;
    logic [15:0]       impl_tbl [4] = '{16'hFFFB, 16'hDFFF, 16'h21FF, 16'h00F6};
    int                miscompares, num_checks;

    iemb_bank u_iemb_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .req_to_arb(req_to_arb), .best_prio(best_prio), .best_src(best_src), .irq(irq));

    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One APB transfer; an idle edge first keeps back-to-back calls race free
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            miscompares++;
            $display("CHECK FAILED at %0t: no pready", $time);
            end_of_test();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        chk({er, rd}, {e, exp});
    endtask

    // One-cycle request pulse, then the fixed two-edge latency plus margin
    task automatic pulse(input logic [63:0] m);
        @(posedge pclk);
        src_req <= m;
        @(posedge pclk);
        src_req <= '0;
        repeat (3) @(posedge pclk);
    endtask

    // Watchdog
    initial begin
        repeat (50000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, src_req} = '0;
        pstrb = 4'hF;
        miscompares = 0;
        num_checks = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            ea = OFF_ENABLE_BASE + 12'(4 * r);
            rdchk(ea, 32'h0, 1'b0);
            apb(1'b1, ea, 32'hFFFF_FFFF);
            rdchk(ea, {16'h0, impl_tbl[r]}, 1'b0);
            apb(1'b1, ea, 32'h0);
            rdchk(ea, 32'h0, 1'b0);
        end
        apb(1'b1, 12'h002, 32'hFFFF);
        chk(er, 1'b1);
        rdchk(OFF_ENABLE_BASE, 32'h0, 1'b0);
        rdchk(12'h034, 32'h0, 1'b1);
        // Only the strobed upper lane of register c takes the write
        pstrb <= 4'h2;
        apb(1'b1, 12'h004, 32'hFFFF);
        pstrb <= 4'hF;
        rdchk(12'h004, 32'hDF00, 1'b0);
        apb(1'b1, 12'h004, 32'h0);
        $display("test register access done");
        // Every position: flag sets while masked, passes only when enabled and present
        for (int k = 0; k < 64; k++) begin
            ea = OFF_ENABLE_BASE + 12'(4 * (k / 16));
            fa = OFF_FLAG_BASE + 12'(4 * (k / 16));
            pa = OFF_PEND_BASE + 12'(4 * (k / 16));
            pulse(64'h1 << k);
            chk(irq, 1'b0);
            rdchk(fa, {16'h0, impl_tbl[k / 16] & (16'h1 << (k % 16))}, 1'b0);
            apb(1'b1, ea, 32'hFFFF);
            repeat (3) @(posedge pclk);
            chk(req_to_arb, impl_tbl[k / 16][k % 16] ? 64'h1 << k : 64'h0);
            chk(irq, impl_tbl[k / 16][k % 16]);
            chk({best_prio, best_src}, impl_tbl[k / 16][k % 16] ? {3'h4, 6'(k)} : 9'h0);
            rdchk(pa, {16'h0, impl_tbl[k / 16] & (16'h1 << (k % 16))}, 1'b0);
            rdchk(OFF_BEST, impl_tbl[k / 16][k % 16] ? {21'h0, 3'h4, 2'h0, 6'(k)} : 32'h0, 1'b0);
            apb(1'b1, ea, 32'h0);
            repeat (3) @(posedge pclk);
            chk(irq, 1'b0);
            apb(1'b1, fa, 32'h1 << (k % 16));
            rdchk(fa, 32'h0, 1'b0);
        end
        $display("test source gating done");
        // Priority zero blocks an enabled source; seven beats two
        apb(1'b1, OFF_PRIO_BASE, 32'h20);
        apb(1'b1, OFF_ENABLE_BASE, 32'h3);
        pulse(64'h3);
        chk(req_to_arb, 64'h2);
        chk({best_prio, best_src}, {3'h2, 6'h1});
        apb(1'b1, OFF_PRIO_BASE, 32'h27);
        rdchk(OFF_PRIO_BASE, 32'h27, 1'b0);
        repeat (3) @(posedge pclk);
        chk({req_to_arb, best_prio, best_src}, {64'h3, 3'h7, 6'h0});
        $display("test priority done");
        // Reset in mid-run clears live enables, flags and the interrupt, and returns priorities to 4
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        chk(req_to_arb, 64'h0);
        presetn <= 1'b1;
        rdchk(OFF_ENABLE_BASE, 32'h0, 1'b0);
        rdchk(OFF_FLAG_BASE, 32'h0, 1'b0);
        rdchk(OFF_PRIO_BASE, 32'h4444, 1'b0);
        $display("test second reset done");
        end_of_test();
    end
endmodule // iemb_bank_tb
